// file: hw/ledic_pkg.sv
/*
 * Package for the front-panel indicator controller: colour codes, carrier
 * structs, boot lamp-test phases and blink timing constants.
 * Assumes a single 100 MHz system clock shared by every user of the package.
 */
package ledic_pkg;

    // Colour carried to each lamp driver.
    typedef enum logic [1:0] {
        LEDIC_OFF   = 2'h0,
        LEDIC_GREEN = 2'h1,
        LEDIC_AMBER = 2'h2,
        LEDIC_RED   = 2'h3
    } ledic_colour_t;

    // Boot lamp-test phases, one-hot.
    typedef enum logic [4:0] {
        LEDIC_PH_GREEN = 5'h01,
        LEDIC_PH_RED   = 5'h02,
        LEDIC_PH_AMBER = 5'h04,
        LEDIC_PH_DARK  = 5'h08,
        LEDIC_PH_NORM  = 5'h10
    } ledic_phase_t;

    // The four indicator colours as one group.
    typedef struct packed {
        ledic_colour_t supply;
        ledic_colour_t status;
        ledic_colour_t port_one;
        ledic_colour_t port_two;
    } ledic_lamps_t;

    // Unit-status condition inputs.
    typedef struct packed {
        logic major_fault;
        logic minor_fault;
        logic booting;
        logic shutting_down;
    } ledic_unit_t;

    // Fronthaul port one condition inputs.
    typedef struct packed {
        logic link_up;
        logic gigabit;
        logic activity;
        logic critical_fault;
    } ledic_port_t;

    // Timing in its own unit, and the derived cycle counts.
    localparam int unsigned LEDIC_CLK_HZ        = 100_000_000;
    localparam int unsigned LEDIC_SLOW_HALF_MS  = 500;
    localparam int unsigned LEDIC_PHASE_MS      = 1000;
    localparam int unsigned LEDIC_FAST_HALF_MS  = 100;
    localparam int unsigned LEDIC_SLOW_HALF_CYC = LEDIC_CLK_HZ / 1000 * LEDIC_SLOW_HALF_MS;
    localparam int unsigned LEDIC_PHASE_CYC     = LEDIC_CLK_HZ / 1000 * LEDIC_PHASE_MS;
    localparam int unsigned LEDIC_FAST_HALF_CYC = LEDIC_CLK_HZ / 1000 * LEDIC_FAST_HALF_MS;
    localparam int unsigned LEDIC_CNT_W         = 27;

    // Reset values.
    localparam ledic_phase_t LEDIC_PHASE_RST = LEDIC_PH_GREEN;
    localparam logic         LEDIC_BLINK_RST = 1'b1;

endpackage : ledic_pkg

// file: hw/ledic_top.sv
/*
 * Front-panel indicator controller: maps supply, unit-status and fronthaul
 * conditions to four lamp colours, with slow and fast blink and a boot lamp test.
 * Assumes all condition inputs are synchronous to ref_clk and that the lamp
 * drivers decode the two-bit colour code themselves.
 */
`timescale 1ns/1ps
`default_nettype none
module ledic_top
    import ledic_pkg::*;
#(
    parameter int unsigned SLOW_HALF_CYC = LEDIC_SLOW_HALF_CYC,
    parameter int unsigned PHASE_CYC     = LEDIC_PHASE_CYC,
    parameter int unsigned FAST_HALF_CYC = LEDIC_FAST_HALF_CYC
)
(
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         supply_present,
    input  wire logic         supply_fault,
    input  wire ledic_unit_t  unit_cond,
    input  wire ledic_port_t  port_cond,
    input  wire logic         locate_req,
    output var  ledic_lamps_t lamps,
    output var  logic         lamp_test_busy
);

    // All module state except the two reset synchroniser flops in one packed struct.
    typedef struct packed {
        ledic_phase_t            phase;
        logic [LEDIC_CNT_W-1:0]  phase_cnt;
        logic [LEDIC_CNT_W-1:0]  slow_cnt;
        logic                    slow_on;
        logic [LEDIC_CNT_W-1:0]  fast_cnt;
        logic                    fast_on;
        ledic_lamps_t            lamps;
    } ledic_state_t;

    ledic_state_t state_r;
    ledic_state_t state_nxt;
    logic         rst_sync1_r;
    logic         rst_sync2_r;
    logic         srst_n;

    // Reset release passes two flops so the design leaves reset cleanly.
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end
        else
        begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    assign srst_n = rst_sync2_r;

    // Apply a blink gate to a colour: dark during the off half.
    function automatic ledic_colour_t ledic_gate(input ledic_colour_t c, input logic on);
        ledic_gate = on ? c : LEDIC_OFF;
    endfunction : ledic_gate

    // Timers, lamp-test sequencer and colour selection.
    always_comb
    begin
        state_nxt = state_r;

        // Slow blink half-period counter.
        if (state_r.slow_cnt == LEDIC_CNT_W'(SLOW_HALF_CYC - 1))
        begin
            state_nxt.slow_cnt = '0;
            state_nxt.slow_on  = ~state_r.slow_on;
        end
        else
        begin
            state_nxt.slow_cnt = state_r.slow_cnt + 1'b1;
        end

        // Fast blink runs free; its rate need only be clearly quicker.
        if (state_r.fast_cnt == LEDIC_CNT_W'(FAST_HALF_CYC - 1))
        begin
            state_nxt.fast_cnt = '0;
            state_nxt.fast_on  = ~state_r.fast_on;
        end
        else
        begin
            state_nxt.fast_cnt = state_r.fast_cnt + 1'b1;
        end

        // Lamp-test phase sequencer; it restarts whenever supply is lost.
        if (!supply_present)
        begin
            state_nxt.phase     = LEDIC_PH_GREEN;
            state_nxt.phase_cnt = '0;
        end
        else if (state_r.phase != LEDIC_PH_NORM)
        begin
            if (state_r.phase_cnt == LEDIC_CNT_W'(PHASE_CYC - 1))
            begin
                state_nxt.phase_cnt = '0;
                unique case (state_r.phase)
                    LEDIC_PH_GREEN: state_nxt.phase = LEDIC_PH_RED;
                    LEDIC_PH_RED:   state_nxt.phase = LEDIC_PH_AMBER;
                    LEDIC_PH_AMBER: state_nxt.phase = LEDIC_PH_DARK;
                    LEDIC_PH_DARK:  state_nxt.phase = LEDIC_PH_NORM;
                    default:        state_nxt.phase = LEDIC_PH_NORM;
                endcase
            end
            else
            begin
                state_nxt.phase_cnt = state_r.phase_cnt + 1'b1;
            end
        end

        // Supply indicator in normal running.
        if (supply_fault)
            state_nxt.lamps.supply = LEDIC_RED;
        else
            state_nxt.lamps.supply = LEDIC_GREEN;

        // Status indicator, most severe condition first.
        if (unit_cond.major_fault)
            state_nxt.lamps.status = LEDIC_RED;
        else if (unit_cond.minor_fault)
            state_nxt.lamps.status = LEDIC_AMBER;
        else if (unit_cond.booting || unit_cond.shutting_down)
            state_nxt.lamps.status = ledic_gate(LEDIC_GREEN, state_r.slow_on);
        else
            state_nxt.lamps.status = LEDIC_GREEN;

        // Port one: a critical fault outranks any link indication.
        if (unit_cond.booting)
            state_nxt.lamps.port_one = LEDIC_OFF;
        else if (port_cond.critical_fault)
            state_nxt.lamps.port_one = LEDIC_RED;
        else if (!port_cond.link_up)
            state_nxt.lamps.port_one = LEDIC_OFF;
        else if (!port_cond.gigabit)
            state_nxt.lamps.port_one = LEDIC_AMBER;
        else if (port_cond.activity)
            state_nxt.lamps.port_one = ledic_gate(LEDIC_GREEN, state_r.slow_on);
        else
            state_nxt.lamps.port_one = LEDIC_GREEN;

        // Port two is reserved.
        state_nxt.lamps.port_two = LEDIC_OFF;

        // Locate request flashes the status lamp amber over normal display.
        if (locate_req)
            state_nxt.lamps.status = ledic_gate(LEDIC_AMBER, state_r.fast_on);

        // Lamp test overrides normal display until it completes.
        unique case (state_nxt.phase)
            LEDIC_PH_GREEN:
            begin
                state_nxt.lamps.status   = LEDIC_GREEN;
                state_nxt.lamps.port_one = LEDIC_GREEN;
                state_nxt.lamps.port_two = LEDIC_GREEN; // Supply keeps hardware state.
            end
            LEDIC_PH_RED:
            begin
                state_nxt.lamps = '{LEDIC_RED, LEDIC_RED, LEDIC_RED, LEDIC_RED};
            end
            LEDIC_PH_AMBER:
            begin
                state_nxt.lamps = '{LEDIC_RED, LEDIC_AMBER, LEDIC_AMBER, LEDIC_AMBER};
            end
            LEDIC_PH_DARK:
            begin
                state_nxt.lamps = '{LEDIC_RED, LEDIC_OFF, LEDIC_OFF, LEDIC_OFF};
            end
            LEDIC_PH_NORM:
            begin
            end
            default:
            begin
                state_nxt.phase = LEDIC_PH_GREEN;
            end
        endcase

        // No supply means every lamp dark, whatever else is asserted.
        if (!supply_present)
            state_nxt.lamps = '{LEDIC_OFF, LEDIC_OFF, LEDIC_OFF, LEDIC_OFF};
    end

    // State register; lamps reset dark so no colour glitches at power-up.
    always_ff @(posedge ref_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            state_r.phase     <= LEDIC_PHASE_RST;
            state_r.phase_cnt <= '0;
            state_r.slow_cnt  <= '0;
            state_r.slow_on   <= LEDIC_BLINK_RST;
            state_r.fast_cnt  <= '0;
            state_r.fast_on   <= LEDIC_BLINK_RST;
            state_r.lamps     <= '{LEDIC_OFF, LEDIC_OFF, LEDIC_OFF, LEDIC_OFF};
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Two-bit codes make each lamp exactly one colour at all times.
    assign lamps          = state_r.lamps;
    assign lamp_test_busy = (state_r.phase != LEDIC_PH_NORM);

endmodule : ledic_top
`default_nettype wire

// file: test/ledic_top_properties.sv
/* Port checker for the indicator controller.
   Assumes it is bound into ledic_top and sees only that module's ports. */
`timescale 1ns/1ps
`default_nettype none
module ledic_top_properties
    import ledic_pkg::*;
#(
    parameter int unsigned SLOW_HALF_CYC = 8,
    parameter int unsigned PHASE_CYC     = 20,
    parameter int unsigned FAST_HALF_CYC = 3
)
(
    input wire logic         ref_clk,
    input wire logic         rst_n,
    input wire logic         supply_present,
    input wire logic         supply_fault,
    input wire ledic_unit_t  unit_cond,
    input wire ledic_port_t  port_cond,
    input wire logic         locate_req,
    input wire ledic_lamps_t lamps,
    input wire logic         lamp_test_busy
);
    // Lamps lag the reset release by the synchroniser, so checks wait it out.
    logic [1:0] up_r;
    logic       run;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
    assign run = (up_r == 2'h3) && supply_present && !lamp_test_busy;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_dark_unpowered: assert property (!supply_present |=> lamps == '0)
        else $error("lamps lit without supply");
    a_restart_test: assert property (!supply_present |=> lamp_test_busy)
        else $error("lamp test not restarted");
    a_supply_red: assert property ((up_r == 2'h3) && supply_present && supply_fault
        |=> lamps.supply == LEDIC_RED) else $error("supply lamp not red");
    a_supply_green: assert property (run && !supply_fault |=> lamps.supply == LEDIC_GREEN)
        else $error("supply lamp not green");
    a_major_red: assert property (run && unit_cond.major_fault && !locate_req
        |=> lamps.status == LEDIC_RED) else $error("status not red");
    a_minor_amber: assert property (run && unit_cond[3:2] == 2'h1 && !locate_req
        |=> lamps.status == LEDIC_AMBER) else $error("status not amber");
    a_status_green: assert property (run && unit_cond == 4'h0 && !locate_req
        |=> lamps.status == LEDIC_GREEN) else $error("status not green");
    a_port_boot: assert property (run && unit_cond.booting |=> lamps.port_one == LEDIC_OFF)
        else $error("port one lit while booting");
    a_port_crit: assert property (run && !unit_cond.booting && port_cond.critical_fault
        |=> lamps.port_one == LEDIC_RED) else $error("port one not red");
    a_port_slow: assert property (run && !unit_cond.booting && port_cond == 4'h8
        |=> lamps.port_one == LEDIC_AMBER) else $error("port one not amber");
    a_port_idle: assert property (run && !unit_cond.booting && port_cond == 4'hC
        |=> lamps.port_one == LEDIC_GREEN) else $error("port one not green");
    a_port_two_off: assert property (run |=> lamps.port_two == LEDIC_OFF)
        else $error("port two lit");
endmodule : ledic_top_properties

bind ledic_top ledic_top_properties #(
    .SLOW_HALF_CYC(SLOW_HALF_CYC), .PHASE_CYC(PHASE_CYC), .FAST_HALF_CYC(FAST_HALF_CYC)
) i_props (.ref_clk, .rst_n, .supply_present, .supply_fault, .unit_cond, .port_cond,
    .locate_req, .lamps, .lamp_test_busy);
`default_nettype wire

// file: test/ledic_lamp_model.sv
/* Behavioural model of the four front-panel lamps.
   Assumes the lamp code changes only on rising edges of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module ledic_lamp_model
    import ledic_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire ledic_lamps_t lamps,
    output var  logic [7:0]   status_run
);
    logic [7:0]    run_len = 8'h00;
    ledic_colour_t prev    = LEDIC_OFF;
    initial status_run = 8'h00;
    // Each lamp shows one colour of four; the status lamp's steady runs are
    // timed so the bench can see blink half periods.
    always @(posedge ref_clk)
    begin
        prev <= lamps.status;
        if (lamps.status !== prev)
        begin
            status_run <= run_len;
            run_len    <= 8'h01;
        end
        else run_len <= run_len + 8'h01;
    end
endmodule : ledic_lamp_model
`default_nettype wire

// file: test/test_ledic_top.sv
/* Self-checking bench for the indicator controller.
   Assumes the lamp model and short timing parameters for simulation. */
`timescale 1ns/1ps
`default_nettype none
module test_ledic_top
    import ledic_pkg::*;
;
    localparam int unsigned   SLOW = 8;
    localparam int unsigned   FAST = 3;
    localparam ledic_colour_t GN   = LEDIC_GREEN;
    localparam ledic_colour_t AM   = LEDIC_AMBER;
    localparam ledic_colour_t RD   = LEDIC_RED;
    localparam ledic_colour_t NO   = LEDIC_OFF;
    logic          ref_clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          supply_present = 1'b1;
    logic          supply_fault = 1'b0;
    ledic_unit_t   unit_cond = '0;
    ledic_port_t   port_cond = '0;
    logic          locate_req = 1'b0;
    ledic_lamps_t  lamps;
    logic          lamp_test_busy;
    logic [7:0]    status_run;
    ledic_colour_t c0;
    int            fails = 0;
    int            n_compared = 0;
    int            cycles = 0;

    ledic_top #(.SLOW_HALF_CYC(SLOW), .PHASE_CYC(20), .FAST_HALF_CYC(FAST)) i_dut (
        .ref_clk, .rst_n, .supply_present, .supply_fault, .unit_cond, .port_cond,
        .locate_req, .lamps, .lamp_test_busy);
    ledic_lamp_model i_lamps (.ref_clk, .lamps, .status_run);

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Inputs always move 1 ns after an edge, clear of the sampling instant.
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic try(input logic sf, input logic [3:0] u, input logic [3:0] p,
                       input ledic_lamps_t exp);
        supply_fault = sf;
        unit_cond    = u;
        port_cond    = p;
        step(2);
        chk(lamps, exp);
    endtask : try

    // The whole sequence takes about 165 cycles, so 1000 means a hang.
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            fails++;
            close_out();
        end
    end

    // Lamp test phases are sampled near their middles, then normal mapping.
    initial
    begin
        step(4);
        rst_n = 1'b1;
        step(10);
        chk(lamps, {GN, GN, GN, GN});
        supply_fault = 1'b1;
        step(3);
        chk(lamps.supply, RD);
        supply_fault = 1'b0;
        step(19);
        chk(lamps, {RD, RD, RD, RD});
        step(20);
        chk(lamps, {RD, AM, AM, AM});
        step(20);
        chk(lamps, {RD, NO, NO, NO});
        for (int i = 0; i < 40 && lamp_test_busy !== 1'b0; i++) step(1);
        chk(lamp_test_busy, 1'b0);
        try(1'b0, 4'h0, 4'hC, {GN, GN, GN, NO});
        try(1'b1, 4'h4, 4'h8, {RD, AM, AM, NO});
        try(1'b0, 4'hC, 4'hD, {GN, RD, RD, NO});
        try(1'b0, 4'h6, 4'hC, {GN, AM, NO, NO});
        try(1'b0, 4'h0, 4'h0, {GN, GN, NO, NO});
        // Blink phase is free-running, so only the steady lamps are compared here.
        supply_fault = 1'b0;
        unit_cond    = 4'h1;
        port_cond    = 4'hE;
        step(2);
        chk({lamps.supply, lamps.port_two}, {GN, NO});
        step(4 * SLOW);
        chk(status_run, 8'(SLOW));
        c0 = lamps.port_one;
        step(SLOW);
        chk(c0 ^ lamps.port_one, GN);
        chk(c0 | lamps.port_one, GN);
        locate_req = 1'b1;
        unit_cond  = 4'h0;
        step(6 * FAST + 2);
        chk(status_run, 8'(FAST));
        locate_req     = 1'b0;
        supply_present = 1'b0;
        step(2);
        chk(lamps, 8'h00);
        chk(lamp_test_busy, 1'b1);
        supply_present = 1'b1;
        step(5);
        chk(lamps, {GN, GN, GN, GN});
        close_out();
    end
endmodule : test_ledic_top
`default_nettype wire
